/* File: src/ump_pkg.sv */
/*
  Shared constants and types for the serial mute/parity/LIN/sync core.
  Assumes a 16x oversampling tick from the baud generator on the core clock.
*/
package ump_pkg;
  localparam int OS_N = 16;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h8;
  localparam logic [3:0] SMP_A = 4'h7;
  localparam logic [3:0] SMP_B = 4'h8;
  localparam logic [3:0] SMP_C = 4'h9;
  localparam logic [3:0] CK_HALF = 4'h8;
  localparam logic [3:0] NB_BASE = 4'h8;
  localparam logic [3:0] LIN_BRK_N = 4'hD;
  localparam logic [3:0] BRK_SHORT = 4'hA;
  localparam logic [3:0] BRK_LONG = 4'hB;
  localparam logic [3:0] BRK_ZERO_INIT = 4'h1;
  localparam logic [3:0] ZERO_MAX = 4'hF;
  localparam logic [8:0] MASK_W8 = 9'h0FF;
  localparam logic [8:0] MASK_W7 = 9'h07F;
  localparam logic [8:0] MASK_W9 = 9'h1FF;

  typedef enum logic [1:0] {
    UMP_HUNT = 2'b00,
    UMP_START = 2'b01,
    UMP_RUN = 2'b10
  } ump_smp_e;

  typedef enum logic [1:0] {
    UMP_T_IDLE = 2'b00,
    UMP_T_FRAME = 2'b01,
    UMP_T_BREAK = 2'b10,
    UMP_T_MARK = 2'b11
  } ump_tx_e;

  typedef struct packed {
    logic word_len9;
    logic parity_enable;
    logic parity_select;
    logic wake_addr_mark;
    logic lin_mode_enable;
    logic break_length_sel;
    logic sync_clock_enable;
    logic last_bit_clock_sel;
    logic clock_polarity_sel;
    logic clock_phase_sel;
    logic transmitter_enable;
    logic receiver_enable;
    logic parity_error_irq_en;
    logic break_irq_en;
  } ump_cfg_s;

  typedef struct packed {
    logic par_err;
    logic [8:0] data;
  } ump_rxw_s;
endpackage

/* File: src/ump_bit_sampler.sv */
/*
  Oversampled start-bit hunter and bit sampler with 3-sample majority vote.
  Assumes the line input is already synchronised to clock_i.
*/
`timescale 1ns/1ns
`default_nettype none
module ump_bit_sampler #(
  parameter int OS_N = ump_pkg::OS_N
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic line_i,
  input wire logic tick_i,
  input wire logic restart_i,
  output logic bit_v_o,
  output logic bit_o,
  output logic busy_o
);
  if (OS_N != 16)
  begin : g_bad_os
    $error("ump_bit_sampler: sample points need 16x oversampling");
  end

  ump_pkg::ump_smp_e st_reg;
  logic [3:0] os_reg;
  logic [1:0] ones_reg;
  logic bit_v_reg;
  logic bit_reg;
  wire in_window = (os_reg == ump_pkg::SMP_A) || (os_reg == ump_pkg::SMP_B)
    || (os_reg == ump_pkg::SMP_C);
  wire [1:0] ones_next = ones_reg + {1'b0, line_i};
  wire majority = ones_next[1];

  always_ff @(posedge clock_i)
  begin
    if (rst_i || !en_i || restart_i)
    begin
      st_reg <= ump_pkg::UMP_HUNT;
      os_reg <= 4'h0;
      ones_reg <= 2'h0;
      bit_v_reg <= 1'b0;
      bit_reg <= 1'b1;
    end
    else
    begin
      bit_v_reg <= 1'b0;
      if (tick_i)
      begin
        unique case (st_reg)
          ump_pkg::UMP_HUNT:
            if (!line_i)
            begin
              st_reg <= ump_pkg::UMP_START;
              os_reg <= 4'h1;
            end
          ump_pkg::UMP_START:
          begin
            os_reg <= os_reg + 4'h1;
            // a glitch shorter than half a bit is not a start
            if (os_reg == ump_pkg::OS_MID && line_i)
              st_reg <= ump_pkg::UMP_HUNT;
            else if (os_reg == ump_pkg::OS_LAST)
            begin
              st_reg <= ump_pkg::UMP_RUN;
              ones_reg <= 2'h0;
            end
          end
          ump_pkg::UMP_RUN:
          begin
            os_reg <= os_reg + 4'h1;
            if (in_window)
              ones_reg <= ones_next;
            if (os_reg == ump_pkg::SMP_C)
            begin
              bit_v_reg <= 1'b1;
              bit_reg <= majority;
            end
            if (os_reg == ump_pkg::OS_LAST)
              ones_reg <= 2'h0;
          end
          default:
            st_reg <= ump_pkg::UMP_HUNT;
        endcase
      end
    end
  end

  assign bit_v_o = bit_v_reg;
  assign bit_o = bit_reg;
  assign busy_o = (st_reg != ump_pkg::UMP_HUNT);
endmodule
`default_nettype wire

/* File: src/ump_serial_core.sv */
/*
  Serial core: receiver mute/wake, parity, LIN break send/detect,
  synchronous master clock, two-entry receive buffer.
  Assumes a one-cycle 16x oversampling tick from a baud generator on
  clock_i; rx_i is asynchronous to clock_i.
*/
`timescale 1ns/1ns
`default_nettype none
module ump_serial_core #(
  parameter int ADDR_W = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic os_tick_i,
  input wire logic rx_i,
  input wire ump_pkg::ump_cfg_s cfg_i,
  input wire logic [ADDR_W-1:0] node_addr_i,
  input wire logic mute_wr_i,
  input wire logic mute_wr_val_i,
  input wire logic send_break_req_i,
  input wire logic pe_clr_i,
  input wire logic brk_clr_i,
  input wire logic tx_valid_i,
  input wire logic [8:0] tx_data_i,
  output logic tx_ready_o,
  input wire logic rx_ready_i,
  output ump_pkg::ump_rxw_s rx_word_o,
  output logic receive_not_empty_flag_o,
  output logic receiver_mute_ctl_o,
  output logic parity_error_flag_o,
  output logic break_detected_flag_o,
  output logic irq_o,
  output logic tx_o,
  output logic bit_clock_out_o
);
  if (ADDR_W < 1 || ADDR_W > 7)
  begin : g_bad_addr
    $error("ump_serial_core: node address must fit below the msb");
  end

  logic rx_m_reg;
  logic rx_s_reg;
  ump_pkg::ump_tx_e tx_st_reg;
  logic [3:0] tx_os_reg;
  logic [3:0] tx_idx_reg;
  logic [10:0] tx_frame_reg;
  logic tx_ready_reg;
  logic tx_line_reg;
  logic ck_reg;
  logic brk_pend_reg;
  logic [8:0] rx_word_reg;
  logic [3:0] a_cnt_reg;
  logic halt_reg;
  logic [3:0] zeros_reg;
  logic [7:0] idle_cnt_reg;
  logic mute_reg;
  logic pe_reg;
  logic brk_reg;
  logic irq_reg;
  ump_pkg::ump_rxw_s head_reg;
  ump_pkg::ump_rxw_s tail_reg;
  logic head_v_reg;
  logic tail_v_reg;
  logic a_bit_v;
  logic a_bit;
  logic a_busy;
  logic b_bit_v;
  logic b_bit;
  logic b_busy;

  // two flops before any logic looks at the line
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rx_m_reg <= 1'b1;
      rx_s_reg <= 1'b1;
    end
    else
    begin
      rx_m_reg <= rx_i;
      rx_s_reg <= rx_m_reg;
    end
  end

  // frame shape
  wire [3:0] nbits = ump_pkg::NB_BASE + {3'h0, cfg_i.word_len9};
  wire [3:0] stop_idx = nbits + 4'h1;
  wire [3:0] brk_last = cfg_i.lin_mode_enable ? ump_pkg::LIN_BRK_N - 4'h1
    : nbits + 4'h1;
  wire [8:0] par_mask = cfg_i.word_len9 ? ump_pkg::MASK_W8
    : ump_pkg::MASK_W7;
  wire [8:0] chk_mask = cfg_i.word_len9 ? ump_pkg::MASK_W9
    : ump_pkg::MASK_W8;

  // transmit frame build
  wire tx_par = ^(tx_data_i & par_mask) ^ cfg_i.parity_select;
  wire [8:0] tx_pay_p = cfg_i.word_len9 ? {tx_par, tx_data_i[7:0]}
    : {1'b1, tx_par, tx_data_i[6:0]};
  wire [8:0] tx_pay_n = cfg_i.word_len9 ? tx_data_i
    : {1'b1, tx_data_i[7:0]};
  wire [8:0] tx_pay = cfg_i.parity_enable ? tx_pay_p : tx_pay_n;
  wire [10:0] tx_frame_w = {1'b1, tx_pay, 1'b0};

  // transmit sequencing
  wire tx_idle = (tx_st_reg == ump_pkg::UMP_T_IDLE);
  wire tx_in_frame = (tx_st_reg == ump_pkg::UMP_T_FRAME);
  wire bit_end = os_tick_i && (tx_os_reg == ump_pkg::OS_LAST);
  wire tx_take = tx_ready_reg && tx_valid_i;
  wire brk_go = tx_idle && brk_pend_reg && cfg_i.transmitter_enable;
  wire tx_last = (tx_in_frame && tx_idx_reg == stop_idx)
    || (tx_st_reg == ump_pkg::UMP_T_BREAK && tx_idx_reg == brk_last)
    || (tx_st_reg == ump_pkg::UMP_T_MARK);
  wire ump_pkg::ump_tx_e tx_st_end =
    (tx_st_reg == ump_pkg::UMP_T_BREAK) ? ump_pkg::UMP_T_MARK
    : ump_pkg::UMP_T_IDLE;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_st_reg <= ump_pkg::UMP_T_IDLE;
      tx_os_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      tx_frame_reg <= 11'h7FF;
    end
    else if (tx_idle)
    begin
      tx_os_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      if (brk_go)
        tx_st_reg <= ump_pkg::UMP_T_BREAK;
      else if (tx_take)
      begin
        tx_st_reg <= ump_pkg::UMP_T_FRAME;
        tx_frame_reg <= tx_frame_w;
      end
    end
    else
    begin
      if (os_tick_i)
        tx_os_reg <= tx_os_reg + 4'h1;
      if (bit_end && tx_last)
      begin
        tx_st_reg <= tx_st_end;
        tx_idx_reg <= 4'h0;
      end
      else if (bit_end)
        tx_idx_reg <= tx_idx_reg + 4'h1;
    end
  end

  // break request is held until the transmitter is free; set wins
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      brk_pend_reg <= 1'b0;
    else
      brk_pend_reg <= send_break_req_i || (brk_pend_reg && !brk_go);
  end

  // synchronous clock: data bits only, last one optional
  wire in_data = tx_in_frame && tx_idx_reg != 4'h0 && tx_idx_reg <= nbits;
  wire last_ok = (tx_idx_reg != nbits) || cfg_i.last_bit_clock_sel;
  wire half_act = cfg_i.clock_phase_sel ? (tx_os_reg < ump_pkg::CK_HALF)
    : (tx_os_reg >= ump_pkg::CK_HALF);
  wire ck_act = cfg_i.sync_clock_enable && cfg_i.transmitter_enable
    && in_data && last_ok && half_act;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_ready_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      ck_reg <= 1'b0;
    end
    else
    begin
      tx_ready_reg <= tx_idle && !tx_take && !brk_go && !brk_pend_reg
        && cfg_i.transmitter_enable;
      tx_line_reg <= tx_in_frame ? tx_frame_reg[tx_idx_reg]
        : (tx_st_reg != ump_pkg::UMP_T_BREAK);
      // polarity is taken live, so changing it while enabled glitches
      ck_reg <= cfg_i.clock_polarity_sel ^ ck_act;
    end
  end

  // receive: async sampler is parked in sync mode and while halted
  wire buf_full = head_v_reg && tail_v_reg;
  wire a_en = cfg_i.receiver_enable && !cfg_i.sync_clock_enable
    && !halt_reg && (a_busy || !buf_full);
  wire a_stop = a_bit_v && (a_cnt_reg == nbits);
  wire sync_on = cfg_i.sync_clock_enable && cfg_i.receiver_enable;
  wire sync_pt = sync_on && tx_in_frame && os_tick_i
    && (tx_os_reg == ump_pkg::CK_HALF);
  wire sync_smp = sync_pt && in_data;
  wire sync_done = sync_pt && (tx_idx_reg == stop_idx);
  wire char_done = a_stop || sync_done;
  wire wr_en = sync_smp || (a_bit_v && a_cnt_reg < nbits);
  wire [3:0] wr_idx = sync_on ? tx_idx_reg - 4'h1 : a_cnt_reg;
  wire wr_bit = sync_on ? rx_s_reg : a_bit;

  ump_bit_sampler u_rx_sampler (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .en_i(a_en),
    .line_i(rx_s_reg),
    .tick_i(os_tick_i),
    .restart_i(a_stop),
    .bit_v_o(a_bit_v),
    .bit_o(a_bit),
    .busy_o(a_busy)
  );

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      a_cnt_reg <= 4'h0;
      rx_word_reg <= 9'h000;
    end
    else
    begin
      if (!a_busy)
        a_cnt_reg <= 4'h0;
      else if (a_bit_v)
        a_cnt_reg <= a_cnt_reg + 4'h1;
      if (wr_en)
        rx_word_reg[wr_idx] <= wr_bit;
    end
  end

  // character classification
  wire [3:0] msb_idx = nbits - (cfg_i.parity_enable ? 4'h2 : 4'h1);
  wire is_addr = cfg_i.wake_addr_mark && rx_word_reg[msb_idx];
  wire addr_match = rx_word_reg[ADDR_W-1:0] == node_addr_i;
  wire par_err = cfg_i.parity_enable
    && ((^(rx_word_reg & chk_mask)) != cfg_i.parity_select);
  wire deliver = char_done && (is_addr ? addr_match : !mute_reg);
  wire ferr = a_stop && !a_bit;

  // break detector has its own sampler, fed from the same synchronised line as the data receiver
  wire [3:0] brk_need = cfg_i.break_length_sel ? ump_pkg::BRK_LONG
    : ump_pkg::BRK_SHORT;
  wire b_one = b_bit_v && b_bit;
  wire brk_hit = b_one && (zeros_reg >= brk_need);

  ump_bit_sampler u_brk_sampler (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .en_i(cfg_i.receiver_enable),
    .line_i(rx_s_reg),
    .tick_i(os_tick_i),
    .restart_i(b_one),
    .bit_v_o(b_bit_v),
    .bit_o(b_bit),
    .busy_o(b_busy)
  );

  // the start bit counts as the first zero
  always_ff @(posedge clock_i)
  begin
    if (rst_i || !b_busy)
      zeros_reg <= ump_pkg::BRK_ZERO_INIT;
    else if (b_bit_v && !b_bit && zeros_reg != ump_pkg::ZERO_MAX)
      zeros_reg <= zeros_reg + 4'h1;
  end

  // framing error in LIN mode halts; any one seen by the detector releases
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      halt_reg <= 1'b0;
    else if (ferr && cfg_i.lin_mode_enable)
      halt_reg <= 1'b1;
    else if (b_one || !cfg_i.lin_mode_enable)
      halt_reg <= 1'b0;
  end

  // idle frame: line high for a whole frame while no frame runs
  wire [7:0] idle_len = {nbits + 4'h2, 4'h0};
  wire idle_run = rx_s_reg && !a_busy && cfg_i.receiver_enable
    && !cfg_i.sync_clock_enable;
  wire idle_evt = os_tick_i && idle_run
    && (idle_cnt_reg == idle_len - 8'h01);

  always_ff @(posedge clock_i)
  begin
    if (rst_i || !idle_run)
      idle_cnt_reg <= 8'h00;
    else if (os_tick_i && idle_cnt_reg != idle_len)
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
  end

  // mute control: hardware events outrank a software write
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      mute_reg <= 1'b0;
    else if (char_done && is_addr)
      mute_reg <= !addr_match;
    else if (idle_evt && !cfg_i.wake_addr_mark)
      mute_reg <= 1'b0;
    else if (mute_wr_i && !head_v_reg)
      mute_reg <= mute_wr_val_i;
  end

  // status flags; a setting event beats a clear in the same cycle
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      pe_reg <= 1'b0;
      brk_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      pe_reg <= (pe_reg && !pe_clr_i) || (deliver && par_err);
      brk_reg <= (brk_reg && !brk_clr_i)
        || (brk_hit && cfg_i.lin_mode_enable && !mute_reg);
      irq_reg <= !mute_reg && ((pe_reg && cfg_i.parity_error_irq_en)
        || (brk_reg && cfg_i.break_irq_en));
    end
  end

  // two-entry receive buffer; a word arriving while full is dropped,
  // but the async sampler will not start a new frame while full
  wire pop = head_v_reg && rx_ready_i;
  wire ump_pkg::ump_rxw_s push_w = '{par_err: par_err,
    data: rx_word_reg & chk_mask};

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg <= '0;
      tail_reg <= '0;
    end
    else if (pop)
    begin
      head_reg <= tail_v_reg ? tail_reg : push_w;
      head_v_reg <= tail_v_reg || deliver;
      tail_v_reg <= tail_v_reg && deliver;
      if (tail_v_reg && deliver)
        tail_reg <= push_w;
    end
    else if (deliver && !head_v_reg)
    begin
      head_reg <= push_w;
      head_v_reg <= 1'b1;
    end
    else if (deliver && !tail_v_reg)
    begin
      tail_reg <= push_w;
      tail_v_reg <= 1'b1;
    end
  end

  assign tx_ready_o = tx_ready_reg;
  assign rx_word_o = head_reg;
  assign receive_not_empty_flag_o = head_v_reg;
  assign receiver_mute_ctl_o = mute_reg;
  assign parity_error_flag_o = pe_reg;
  assign break_detected_flag_o = brk_reg;
  assign irq_o = irq_reg;
  assign tx_o = tx_line_reg;
  assign bit_clock_out_o = ck_reg;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  chk_mute_quiet: assert property (mute_reg && !char_done |=>
    !$rose(pe_reg) && !$rose(brk_reg))
    else $error("flag rose while muted");
  chk_idle_wake: assert property (idle_evt && !cfg_i.wake_addr_mark
    && !char_done |=> !mute_reg)
    else $error("idle frame did not unmute");
  chk_sw_mute: assert property (mute_wr_i && mute_wr_val_i
    && !head_v_reg && !char_done && !idle_evt |=> mute_reg)
    else $error("software mute write lost");
  chk_mute_wr_block: assert property (mute_wr_i && head_v_reg
    && !char_done && !idle_evt |=> $stable(mute_reg))
    else $error("mute write taken with data pending");
  chk_addr_miss: assert property (char_done && is_addr && !addr_match
    && !pop |=> mute_reg && $stable(head_v_reg) && $stable(tail_v_reg))
    else $error("mismatched address not muted or stored");
  chk_addr_hit: assert property (char_done && is_addr && addr_match
    |=> !mute_reg && head_v_reg)
    else $error("matching address not stored");
  chk_parity_flag: assert property (deliver && par_err
    |=> pe_reg ##1 (irq_o || !cfg_i.parity_error_irq_en || mute_reg))
    else $error("parity error not flagged");
  chk_lin_break: assert property (tx_st_reg == ump_pkg::UMP_T_BREAK
    && bit_end && tx_last && cfg_i.lin_mode_enable
    |-> tx_idx_reg == 4'hC ##2 tx_o)
    else $error("break length wrong");
  chk_ck_quiet: assert property (!tx_in_frame
    |=> bit_clock_out_o == $past(cfg_i.clock_polarity_sel))
    else $error("bit clock active outside data");
  chk_brk_cancel: assert property (b_one && zeros_reg < brk_need
    |=> !$rose(brk_reg))
    else $error("short break flagged");
  chk_halt_free: assert property (halt_reg && b_one && !ferr
    |=> !halt_reg)
    else $error("halt not released");

  cov_deliver: cover property (deliver && par_err);
  cov_break: cover property ($rose(brk_reg));
  cov_idle_wake: cover property (idle_evt && mute_reg);
  cov_sync_char: cover property (sync_done);
endmodule
`default_nettype wire

/* File: tb/ump_node_model.sv */
/*
  Far-side serial node: drives the receive line with whole frames,
  long low stretches and delimiters, 32 core cycles a bit.
  Assumes the bench ticks the 16x oversampler every second cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module ump_node_model (
  input wire logic clock_i,
  output logic rx_o
);
  localparam int BIT_CYC = 32;

  // line idles high, as a pulled-up bus does
  initial rx_o = 1'b1;

  task automatic put(input logic b);
    rx_o = b;
    repeat (BIT_CYC) @(negedge clock_i);
  endtask

  task automatic frame(input logic [8:0] d, input int nb);
    put(1'b0);
    for (int i = 0; i < nb; i++)
    begin
      put(d[i]);
    end
    put(1'b1);
  endtask

  // low stretch counted with the start bit, then a two-bit delimiter
  task automatic low(input int nb);
    repeat (nb) put(1'b0);
    repeat (2) put(1'b1);
  endtask
endmodule
`default_nettype wire

/* File: tb/ump_serial_core_test.sv */
/*
  Self-checking bench for the serial core: parity, mute/wake,
  LIN break send/detect and synchronous clock.
  Assumes ump_pkg and the node model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s exp %h got %h", n, e, g); end end
`define WAITF(c) begin w = 0; while (!(c) && w < 3000) begin \
  @(negedge clock_i); w++; end if (w >= 3000) begin miscompares++; \
  end_sim(); end end
module ump_serial_core_test;
  logic clock_i = 0;
  logic rst_i = 1;
  logic os_tick_i = 0;
  logic rx_i;
  ump_pkg::ump_cfg_s cfg_i = '0;
  logic mute_wr_i = 0, mute_wr_val_i = 0, send_break_req_i = 0;
  logic pe_clr_i = 0, brk_clr_i = 0, tx_valid_i = 0, rx_ready_i = 0;
  logic [8:0] tx_data_i = 9'h000;
  logic tx_ready_o, receive_not_empty_flag_o, receiver_mute_ctl_o;
  logic parity_error_flag_o, break_detected_flag_o, irq_o;
  logic tx_o, bit_clock_out_o, ck_q;
  ump_pkg::ump_rxw_s rx_word_o;
  int miscompares = 0, check_count = 0, w, rises;
  logic [9:0] v;

  initial forever #2 clock_i = ~clock_i;
  always @(negedge clock_i) os_tick_i <= ~os_tick_i;

  ump_node_model ump_node_model_inst (.clock_i(clock_i), .rx_o(rx_i));
  ump_serial_core ump_serial_core_inst (
    .clock_i(clock_i), .rst_i(rst_i), .os_tick_i(os_tick_i), .rx_i(rx_i),
    .cfg_i(cfg_i), .node_addr_i(4'h5), .mute_wr_i(mute_wr_i),
    .mute_wr_val_i(mute_wr_val_i), .send_break_req_i(send_break_req_i),
    .pe_clr_i(pe_clr_i), .brk_clr_i(brk_clr_i), .tx_valid_i(tx_valid_i),
    .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o),
    .rx_ready_i(rx_ready_i), .rx_word_o(rx_word_o),
    .receive_not_empty_flag_o(receive_not_empty_flag_o),
    .receiver_mute_ctl_o(receiver_mute_ctl_o),
    .parity_error_flag_o(parity_error_flag_o),
    .break_detected_flag_o(break_detected_flag_o), .irq_o(irq_o),
    .tx_o(tx_o), .bit_clock_out_o(bit_clock_out_o));

  task end_sim;
    $display("Checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task pulse_mute(input logic val);
    @(negedge clock_i);
    mute_wr_i = 1;
    mute_wr_val_i = val;
    @(negedge clock_i);
    mute_wr_i = 0;
  endtask

  // request held until the edge that sees ready high
  task xmit(input logic [8:0] d);
    @(negedge clock_i);
    tx_data_i = d;
    tx_valid_i = 1;
    w = 0;
    do
    begin
      @(posedge clock_i);
      w++;
    end
    while (tx_ready_o !== 1'b1 && w < 3000);
    if (w >= 3000)
    begin
      miscompares++;
      end_sim();
    end
    @(negedge clock_i);
    tx_valid_i = 0;
  endtask

  // samples mid-bit; v[nb] is the stop bit; counts bit clock rises
  task get_tx(input int nb);
    `WAITF(tx_o === 1'b0)
    rises = 0;
    ck_q = bit_clock_out_o;
    for (int c = 0; c < 32 * nb + 48; c++)
    begin
      @(negedge clock_i);
      if (bit_clock_out_o === 1'b1 && ck_q === 1'b0)
        rises++;
      ck_q = bit_clock_out_o;
      if (c % 32 == 15 && c / 32 >= 1 && c / 32 <= nb + 1)
        v[c / 32 - 1] = tx_o;
    end
  endtask

  task rd(input logic [8:0] d, input logic pe);
    `WAITF(receive_not_empty_flag_o === 1'b1)
    `CHK("rx data", d, rx_word_o.data)
    `CHK("rx parity err", pe, rx_word_o.par_err)
    rx_ready_i = 1;
    @(negedge clock_i);
    rx_ready_i = 0;
  endtask

  // break frames may leave a word behind; drop it before going on
  task drain;
    repeat (3)
    begin
      rx_ready_i = receive_not_empty_flag_o;
      @(negedge clock_i);
      rx_ready_i = 0;
    end
  endtask

  task flag_clr(input logic brk);
    @(negedge clock_i);
    pe_clr_i = !brk;
    brk_clr_i = brk;
    @(negedge clock_i);
    pe_clr_i = 0;
    brk_clr_i = 0;
  endtask

  initial
  begin
    repeat (60000) @(posedge clock_i);
    miscompares++;
    end_sim();
  end

  initial
  begin
    cfg_i.transmitter_enable = 1;
    cfg_i.receiver_enable = 1;
    cfg_i.parity_error_irq_en = 1;
    cfg_i.break_irq_en = 1;
    repeat (3) @(negedge clock_i);
    rst_i = 0;
    repeat (4) @(negedge clock_i);
    cfg_i.parity_enable = 1;
    for (int ps = 0; ps < 2; ps++)
    begin
      cfg_i.parity_select = ps[0];
      xmit(9'h0B5);
      get_tx(8);
      `CHK("tx frame", {1'b1, ps[0], 7'h35}, v[8:0])
    end
    cfg_i.parity_select = 0;
    // word length only changes between frames, never inside a stop bit
    `WAITF(tx_ready_o === 1'b1)
    cfg_i.word_len9 = 1;
    xmit(9'h0B5);
    get_tx(9);
    `CHK("tx frame m1", 10'h3B5, v)
    `WAITF(tx_ready_o === 1'b1)
    cfg_i.word_len9 = 0;
    ump_node_model_inst.frame(9'h035, 8);
    rd(9'h035, 1'b0);
    `CHK("pe flag", 1'b0, parity_error_flag_o)
    ump_node_model_inst.frame(9'h0B5, 8);
    rd(9'h0B5, 1'b1);
    `CHK("pe flag", 1'b1, parity_error_flag_o)
    `CHK("irq", 1'b1, irq_o)
    flag_clr(1'b0);
    cfg_i.parity_enable = 0;
    cfg_i.word_len9 = 1;
    ump_node_model_inst.frame(9'h1A5, 9);
    rd(9'h1A5, 1'b0);
    cfg_i.word_len9 = 0;
    cfg_i.wake_addr_mark = 1;
    pulse_mute(1'b1);
    `CHK("mute", 1'b1, receiver_mute_ctl_o)
    ump_node_model_inst.frame(9'h012, 8);
    `CHK("receive_not_empty_flag", 1'b0, receive_not_empty_flag_o)
    ump_node_model_inst.frame(9'h083, 8);
    `CHK("receive_not_empty_flag", 1'b0, receive_not_empty_flag_o)
    `CHK("mute", 1'b1, receiver_mute_ctl_o)
    ump_node_model_inst.frame(9'h085, 8);
    `CHK("mute", 1'b0, receiver_mute_ctl_o)
    rd(9'h085, 1'b0);
    ump_node_model_inst.frame(9'h022, 8);
    pulse_mute(1'b1);
    `CHK("mute", 1'b0, receiver_mute_ctl_o)
    rd(9'h022, 1'b0);
    cfg_i.parity_enable = 1;
    ump_node_model_inst.frame(9'h087, 8);
    rd(9'h087, 1'b0);
    `CHK("mute", 1'b0, receiver_mute_ctl_o)
    cfg_i.parity_enable = 0;
    cfg_i.wake_addr_mark = 0;
    pulse_mute(1'b1);
    `CHK("mute", 1'b1, receiver_mute_ctl_o)
    ump_node_model_inst.frame(9'h055, 8);
    `CHK("receive_not_empty_flag", 1'b0, receive_not_empty_flag_o)
    `CHK("mute", 1'b1, receiver_mute_ctl_o)
    repeat (420) @(negedge clock_i);
    `CHK("mute", 1'b0, receiver_mute_ctl_o)
    cfg_i.lin_mode_enable = 1;
    @(negedge clock_i);
    // break length in cycles hangs on the tick phase: start on a known one
    if (os_tick_i !== 1'b1)
      @(negedge clock_i);
    send_break_req_i = 1;
    @(negedge clock_i);
    send_break_req_i = 0;
    `WAITF(tx_o === 1'b0)
    w = 0;
    while (tx_o === 1'b0 && w < 1000)
    begin
      @(negedge clock_i);
      w++;
    end
    `CHK("break len", 416, w)
    repeat (20) @(negedge clock_i);
    `CHK("break mark", 1'b1, tx_o)
    ump_node_model_inst.low(10);
    `CHK("brk flag", 1'b1, break_detected_flag_o)
    `CHK("irq", 1'b1, irq_o)
    flag_clr(1'b1);
    drain();
    cfg_i.break_length_sel = 1;
    ump_node_model_inst.low(10);
    `CHK("brk flag", 1'b0, break_detected_flag_o)
    drain();
    ump_node_model_inst.low(11);
    `CHK("brk flag", 1'b1, break_detected_flag_o)
    flag_clr(1'b1);
    drain();
    ump_node_model_inst.frame(9'h03C, 8);
    rd(9'h03C, 1'b0);
    cfg_i.lin_mode_enable = 0;
    for (int k = 0; k < 4; k++)
    begin
      // clock options only change while both directions are off
      cfg_i.transmitter_enable = 0;
      cfg_i.receiver_enable = 0;
      cfg_i.sync_clock_enable = 1;
      cfg_i.clock_polarity_sel = k[0];
      cfg_i.clock_phase_sel = k[0] ^ k[1];
      cfg_i.last_bit_clock_sel = k[1];
      repeat (2) @(negedge clock_i);
      cfg_i.transmitter_enable = 1;
      cfg_i.receiver_enable = 1;
      xmit(9'h05A);
      // the slave answers in step with our own frame
      fork
        ump_node_model_inst.frame({7'h28, k[1:0]}, 8);
        get_tx(8);
      join
      `CHK("sync frame", {1'b1, 8'h5A}, v[8:0])
      `CHK("ck pulses", 7 + k[1], rises)
      `CHK("ck idle", k[0], bit_clock_out_o)
      rd({7'h28, k[1:0]}, 1'b0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
